//--- design/iplc_pkg.sv
// package: register map, field layout and control carriers of the input loop
package iplc_pkg;

  localparam int unsigned IPLC_AW = 10;
  localparam int unsigned IPLC_DW = 8;

  // register offsets
  localparam logic [9:0] IPLC_OFF_READBACK_SEL  = 10'h004;
  localparam logic [9:0] IPLC_OFF_LOOP_RSVD     = 10'h015;
  localparam logic [9:0] IPLC_OFF_FB_DIV_LOW    = 10'h016;
  localparam logic [9:0] IPLC_OFF_FB_DIV_HIGH   = 10'h017;
  localparam logic [9:0] IPLC_OFF_CP_CURRENT    = 10'h018;
  localparam logic [9:0] IPLC_OFF_CP_MODE_BKL   = 10'h019;
  localparam logic [9:0] IPLC_OFF_RX_CONTROL    = 10'h01A;
  localparam logic [9:0] IPLC_OFF_FB_PATH_MODE  = 10'h01B;

  // writable-bit masks; reserved bits hold zero
  localparam logic [7:0] IPLC_MASK_READBACK_SEL = 8'h01;
  localparam logic [7:0] IPLC_MASK_FB_DIV_LOW   = 8'hFF;
  localparam logic [7:0] IPLC_MASK_FB_DIV_HIGH  = 8'h03;
  localparam logic [7:0] IPLC_MASK_CP_CURRENT   = 8'hFF;
  localparam logic [7:0] IPLC_MASK_CP_MODE_BKL  = 8'h1F;
  localparam logic [7:0] IPLC_MASK_RX_CONTROL   = 8'hFF;
  localparam logic [7:0] IPLC_MASK_FB_PATH_MODE = 8'h3F;

  // reset values
  localparam logic [7:0] IPLC_RST_BYTE          = 8'h00;

  // field positions
  localparam int unsigned IPLC_BIT_CP_TRISTATE  = 7;
  localparam int unsigned IPLC_BIT_BKL_OVERRIDE = 4;
  localparam int unsigned IPLC_BIT_TEST_RX_EN   = 7;
  localparam int unsigned IPLC_BIT_SECOND_REFERENCE_INPUT_DIFF    = 6;
  localparam int unsigned IPLC_BIT_FIRST_REFERENCE_INPUT_DIFF    = 5;
  localparam int unsigned IPLC_BIT_SECOND_REFERENCE_INPUT_EN      = 4;
  localparam int unsigned IPLC_BIT_FIRST_REFERENCE_INPUT_EN      = 3;
  localparam int unsigned IPLC_BIT_RX_PD_CTRL   = 2;
  localparam int unsigned IPLC_BIT_OSC_NEG_SEL  = 1;
  localparam int unsigned IPLC_BIT_OSC_DIFF     = 0;
  localparam int unsigned IPLC_BIT_ZD_INTERNAL  = 5;
  localparam int unsigned IPLC_BIT_OSC_FEEDBACK = 4;
  localparam int unsigned IPLC_BIT_ZD_PIN_SEL   = 3;
  localparam int unsigned IPLC_BIT_ZD_DIFF      = 2;
  localparam int unsigned IPLC_BIT_SECOND_REFERENCE_INPUT_PIN_SEL = 1;
  localparam int unsigned IPLC_BIT_FIRST_REFERENCE_INPUT_PIN_SEL = 0;

  localparam logic [9:0] IPLC_DIV_ONE           = 10'h001;

  typedef enum logic [1:0] {
    IPLC_BKL_MIN  = 2'b00,
    IPLC_BKL_LOW  = 2'b01,
    IPLC_BKL_HIGH = 2'b10,
    IPLC_BKL_MAX  = 2'b11
  } iplc_bkl_e;

  typedef enum logic [1:0] {
    IPLC_CP_TRISTATE = 2'b00,
    IPLC_CP_UP       = 2'b01,
    IPLC_CP_DOWN     = 2'b10,
    IPLC_CP_NORMAL   = 2'b11
  } iplc_cp_mode_e;

  // serial-port side register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       update;
  } iplc_req_s;

  // decoded controls driving the analog loop
  typedef struct packed {
    logic [9:0]    fb_divide;
    logic          cp_hiz;
    logic [6:0]    cp_current;
    iplc_cp_mode_e cp_mode;
    iplc_bkl_e     bkl_period;
    logic          test_rx_en;
    logic          first_reference_input_rx_en;
    logic          second_reference_input_rx_en;
    logic          first_reference_input_diff;
    logic          second_reference_input_diff;
    logic          first_reference_input_pin_neg;
    logic          second_reference_input_pin_neg;
    logic          osc_diff;
    logic          osc_pin_neg;
    logic          osc_feedback;
    logic          zd_rx_en;
    logic          zd_internal;
    logic          zd_diff;
    logic          zd_pin_sel;
  } iplc_ctrl_s;

endpackage : iplc_pkg

//--- design/iplc_decode.sv
// decoder: turns active register bytes into loop control fields
`timescale 1ns/1ns
module iplc_decode
  import iplc_pkg::*;
(
  input  wire logic [7:0] i_div_low,
  input  wire logic [7:0] i_div_high,
  input  wire logic [7:0] i_cp_cur,
  input  wire logic [7:0] i_cp_mode,
  input  wire logic [7:0] i_rx_ctl,
  input  wire logic [7:0] i_fb_mode,
  output iplc_ctrl_s      o_ctrl
);

  logic [9:0] raw_div;

  // combine the two divider bytes; zero is read as divide-by-one
  always_comb begin
    raw_div = {i_div_high[1:0], i_div_low};
    o_ctrl  = '0;
    o_ctrl.fb_divide  = (raw_div == 10'h000) ? IPLC_DIV_ONE : raw_div;
    o_ctrl.cp_hiz     = i_cp_cur[IPLC_BIT_CP_TRISTATE];
    o_ctrl.cp_current = i_cp_cur[6:0];
    o_ctrl.cp_mode    = iplc_cp_mode_e'(i_cp_mode[1:0]);
    // without override the period is pinned to high
    o_ctrl.bkl_period = i_cp_mode[IPLC_BIT_BKL_OVERRIDE]
                      ? iplc_bkl_e'(i_cp_mode[3:2])
                      : IPLC_BKL_HIGH;
    o_ctrl.test_rx_en = i_rx_ctl[IPLC_BIT_TEST_RX_EN];
    o_ctrl.first_reference_input_diff  = i_rx_ctl[IPLC_BIT_FIRST_REFERENCE_INPUT_DIFF];
    o_ctrl.second_reference_input_diff  = i_rx_ctl[IPLC_BIT_SECOND_REFERENCE_INPUT_DIFF];
    // per-receiver enables only count once power-down control is on
    o_ctrl.first_reference_input_rx_en = ~i_rx_ctl[IPLC_BIT_RX_PD_CTRL]
                      | i_rx_ctl[IPLC_BIT_FIRST_REFERENCE_INPUT_EN];
    o_ctrl.second_reference_input_rx_en = ~i_rx_ctl[IPLC_BIT_RX_PD_CTRL]
                      | i_rx_ctl[IPLC_BIT_SECOND_REFERENCE_INPUT_EN];
    o_ctrl.osc_diff    = i_rx_ctl[IPLC_BIT_OSC_DIFF];
    o_ctrl.osc_pin_neg = ~i_rx_ctl[IPLC_BIT_OSC_DIFF]
                       & i_rx_ctl[IPLC_BIT_OSC_NEG_SEL];
    o_ctrl.osc_feedback = i_fb_mode[IPLC_BIT_OSC_FEEDBACK];
    o_ctrl.zd_internal  = ~i_fb_mode[IPLC_BIT_OSC_FEEDBACK]
                        & i_fb_mode[IPLC_BIT_ZD_INTERNAL];
    o_ctrl.zd_rx_en     = ~i_fb_mode[IPLC_BIT_OSC_FEEDBACK]
                        & ~i_fb_mode[IPLC_BIT_ZD_INTERNAL];
    o_ctrl.zd_diff      = i_fb_mode[IPLC_BIT_ZD_DIFF];
    o_ctrl.zd_pin_sel   = ~i_fb_mode[IPLC_BIT_ZD_DIFF]
                        & i_fb_mode[IPLC_BIT_ZD_PIN_SEL];
    o_ctrl.first_reference_input_pin_neg = ~i_rx_ctl[IPLC_BIT_FIRST_REFERENCE_INPUT_DIFF]
                        & i_fb_mode[IPLC_BIT_FIRST_REFERENCE_INPUT_PIN_SEL];
    o_ctrl.second_reference_input_pin_neg = ~i_rx_ctl[IPLC_BIT_SECOND_REFERENCE_INPUT_DIFF]
                        & i_fb_mode[IPLC_BIT_SECOND_REFERENCE_INPUT_PIN_SEL];
  end

endmodule : iplc_decode

//--- design/iplc_regs.sv
// register bank for the input loop: buffer, active copy, readback, decode
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module iplc_regs
  import iplc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire iplc_req_s  i_req,
  output iplc_ctrl_s      o_ctrl,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid
);

  localparam int unsigned NREG = 7;  // buffered bytes loop_reserved_byte..feedback_path_receiver_mode

  typedef struct packed {
    logic [NREG-1:0][7:0] buf_r;
    logic [NREG-1:0][7:0] act_r;
    logic                 rb_sel;
    logic [7:0]           rdata;
    logic                 rvalid;
    iplc_ctrl_s           ctrl;
  } iplc_state_s;

  iplc_state_s state_q;
  iplc_state_s state_d;
  iplc_ctrl_s  dec_ctrl;

  //////////////////////////////////////////////////////////////////////////
  // per-entry write mask table
  function automatic logic [7:0] iplc_mask(input int unsigned idx);
    logic [7:0] m;
    m = 8'h00;
    unique case (idx)
      1: m = IPLC_MASK_FB_DIV_LOW;
      2: m = IPLC_MASK_FB_DIV_HIGH;
      3: m = IPLC_MASK_CP_CURRENT;
      4: m = IPLC_MASK_CP_MODE_BKL;
      5: m = IPLC_MASK_RX_CONTROL;
      6: m = IPLC_MASK_FB_PATH_MODE;
      default: m = 8'h00;  // reserved byte never stores
    endcase
    return m;
  endfunction : iplc_mask

  //////////////////////////////////////////////////////////////////////////
  // decode runs on the active copy so control only moves on update
  iplc_decode u_decode (
    .i_div_low  (state_q.act_r[1]),
    .i_div_high (state_q.act_r[2]),
    .i_cp_cur   (state_q.act_r[3]),
    .i_cp_mode  (state_q.act_r[4]),
    .i_rx_ctl   (state_q.act_r[5]),
    .i_fb_mode  (state_q.act_r[6]),
    .o_ctrl     (dec_ctrl)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state: buffered writes, update copy, readback mux
  always_comb begin
    logic [9:0] idx;
    idx     = i_req.addr - IPLC_OFF_LOOP_RSVD;
    state_d = state_q;
    state_d.rvalid = i_req.rd;
    state_d.rdata  = IPLC_RST_BYTE;
    state_d.ctrl   = dec_ctrl;
    if (i_req.wr) begin
      if (i_req.addr == IPLC_OFF_READBACK_SEL) begin
        state_d.rb_sel = i_req.wdata[0];
      end
      for (int i = 0; i < NREG; i++) begin
        if (idx == 10'(i)) begin
          // reserved bits drop so they read back zero
          state_d.buf_r[i] = i_req.wdata & iplc_mask(i);
        end
      end
    end
    // update copies pending bytes; a write in the same cycle lands next time
    if (i_req.update) begin
      state_d.act_r = state_q.buf_r;
    end
    if (i_req.rd) begin
      if (i_req.addr == IPLC_OFF_READBACK_SEL) begin
        state_d.rdata = {7'h00, state_q.rb_sel};
      end
      for (int i = 0; i < NREG; i++) begin
        if (idx == 10'(i)) begin
          state_d.rdata = state_q.rb_sel ? state_q.buf_r[i]
                                         : state_q.act_r[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // single state register, synchronous reset to all-zero defaults
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_ctrl   = state_q.ctrl;
  assign o_rdata  = state_q.rdata;
  assign o_rvalid = state_q.rvalid;

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_upd;
    i_req.update;
  endsequence

  property p_div_one;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_q.act_r[1] == 8'h00 && state_q.act_r[2][1:0] == 2'b00)
      |=> (o_ctrl.fb_divide == IPLC_DIV_ONE);
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("divide zero not mapped to one");

  property p_hiz;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_upd ##1 1'b1 |=> (o_ctrl.cp_hiz == $past(state_q.act_r[3][7]));
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("pump tristate bit not applied");

  property p_cur;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      1'b1 |=> (o_ctrl.cp_current == $past(state_q.act_r[3][6:0]));
  endproperty
  a_cur: assert property (p_cur)
    else $error("pump current mismatch");

  property p_bkl_auto;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !state_q.act_r[4][4] |=> (o_ctrl.bkl_period == IPLC_BKL_HIGH);
  endproperty
  a_bkl_auto: assert property (p_bkl_auto)
    else $error("antibacklash not forced high");

  property p_bkl_ovr;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      state_q.act_r[4][4]
      |=> (o_ctrl.bkl_period == $past(state_q.act_r[4][3:2]));
  endproperty
  a_bkl_ovr: assert property (p_bkl_ovr)
    else $error("antibacklash width not applied");

  property p_mode;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      1'b1 |=> (o_ctrl.cp_mode == $past(state_q.act_r[4][1:0]));
  endproperty
  a_mode: assert property (p_mode)
    else $error("pump mode mismatch");

  property p_rx_en;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !state_q.act_r[5][2] |=> (o_ctrl.first_reference_input_rx_en && o_ctrl.second_reference_input_rx_en);
  endproperty
  a_rx_en: assert property (p_rx_en)
    else $error("reference receiver powered down without control");

  property p_zd;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      state_q.act_r[6][4] |=> (!o_ctrl.zd_internal && !o_ctrl.zd_rx_en);
  endproperty
  a_zd: assert property (p_zd)
    else $error("zero delay bit not ignored in local feedback");

  property p_reserved;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_req.rd && i_req.addr == IPLC_OFF_LOOP_RSVD)
      |=> (o_rvalid && o_rdata == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved byte reads non-zero");

  property p_pending;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_req.wr && !i_req.update && i_req.addr == IPLC_OFF_CP_CURRENT)
      |=> (state_q.act_r[3] == $past(state_q.act_r[3]));
  endproperty
  a_pending: assert property (p_pending)
    else $error("buffered write reached active copy early");

endmodule : iplc_regs

//--- test/iplc_regs_tb.sv
// testbench: self-checking run of the input loop register bank
`timescale 1ns/1ns
module iplc_regs_tb
  import iplc_pkg::*;
;
  logic       i_sys_clk = 1'b0;
  logic       i_reset_n = 1'b0;
  iplc_req_s  i_req     = '0;
  iplc_ctrl_s o_ctrl;
  logic [7:0] o_rdata;
  logic       o_rvalid;
  int         mismatches = 0;
  int         n_compared = 0;
  // bench copies of buffered and active bytes, 0x016 up to feedback_path_receiver_mode
  logic [7:0] bf [IPLC_OFF_FB_DIV_LOW:IPLC_OFF_FB_PATH_MODE] = '{default: 0};
  logic [7:0] ac [IPLC_OFF_FB_DIV_LOW:IPLC_OFF_FB_PATH_MODE] = '{default: 0};

  // 40 ns clock
  always #20 i_sys_clk = ~i_sys_clk;

  iplc_regs u_iplc_regs (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_req     (i_req),
    .o_ctrl    (o_ctrl),
    .o_rdata   (o_rdata),
    .o_rvalid  (o_rvalid)
  );

  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8

  task automatic chk_ctrl(input iplc_ctrl_s g, input iplc_ctrl_s e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t ctrl got %h exp %h", $time, g, e);
    end
  endtask : chk_ctrl

  // reserved bits are dropped, so the bench copy keeps only writable bits
  function automatic logic [7:0] msk(input logic [9:0] a);
    case (a)
      IPLC_OFF_FB_DIV_HIGH:  msk = IPLC_MASK_FB_DIV_HIGH;
      IPLC_OFF_CP_MODE_BKL:  msk = IPLC_MASK_CP_MODE_BKL;
      IPLC_OFF_FB_PATH_MODE: msk = IPLC_MASK_FB_PATH_MODE;
      default:               msk = 8'hFF;
    endcase
  endfunction : msk

  // expected loop controls worked out from the active bytes
  function automatic iplc_ctrl_s model();
    iplc_ctrl_s e;
    logic [7:0] c, m, x, f;
    c = ac[IPLC_OFF_CP_CURRENT];
    m = ac[IPLC_OFF_CP_MODE_BKL];
    x = ac[IPLC_OFF_RX_CONTROL];
    f = ac[IPLC_OFF_FB_PATH_MODE];
    e = '0;
    e.fb_divide = {ac[IPLC_OFF_FB_DIV_HIGH][1:0], ac[IPLC_OFF_FB_DIV_LOW]};
    if (e.fb_divide == 10'h000)
      e.fb_divide = IPLC_DIV_ONE;
    e.cp_hiz = c[7];
    e.cp_current = c[6:0];
    e.cp_mode = iplc_cp_mode_e'(m[1:0]);
    e.bkl_period = m[4] ? iplc_bkl_e'(m[3:2]) : IPLC_BKL_HIGH;
    {e.test_rx_en, e.second_reference_input_diff, e.first_reference_input_diff} = x[7:5];
    e.second_reference_input_rx_en = x[2] ? x[4] : 1'b1;
    e.first_reference_input_rx_en = x[2] ? x[3] : 1'b1;
    e.osc_diff = x[0];
    // pin selects only count while the receiver is single-ended
    e.osc_pin_neg = x[0] ? 1'b0 : x[1];
    e.osc_feedback = f[4];
    // zero delay mode bit is ignored under local oscillator feedback
    e.zd_internal = f[4] ? 1'b0 : f[5];
    e.zd_rx_en = f[4] ? 1'b0 : ~f[5];
    e.zd_diff = f[2];
    e.zd_pin_sel = f[2] ? 1'b0 : f[3];
    e.second_reference_input_pin_neg = x[6] ? 1'b0 : f[1];
    e.first_reference_input_pin_neg = x[5] ? 1'b0 : f[0];
    return e;
  endfunction : model

  // one request held for exactly one taking edge
  task automatic req(input logic w, r, u, input logic [9:0] a,
                     input logic [7:0] d);
    @(posedge i_sys_clk);
    i_req <= '{wr: w, rd: r, addr: a, wdata: d, update: u};
    @(posedge i_sys_clk);
    i_req <= '0;
  endtask : req

  task automatic put(input logic [9:0] a, input logic [7:0] d);
    req(1'b1, 1'b0, 1'b0, a, d);
    bf[a] = d & msk(a);
  endtask : put

  // controls settle one edge after the update edge; the check waits two falling edges
  task automatic apply(input bit full);
    req(1'b0, 1'b0, 1'b1, 10'h000, 8'h00);
    ac = bf;
    repeat (2) @(negedge i_sys_clk);
    if (full)
      chk_ctrl(o_ctrl, model());
    else
      chk8({7'h00, o_ctrl.osc_feedback}, 8'h01, "osc feedback");
  endtask : apply

  task automatic get(input logic [9:0] a, input logic [7:0] e);
    int i;
    req(1'b0, 1'b1, 1'b0, a, 8'h00);
    #1;
    i = 0;
    while (o_rvalid !== 1'b1 && i < 4) begin
      @(posedge i_sys_clk);
      #1;
      i++;
    end
    if (o_rvalid !== 1'b1) begin
      mismatches++;
      $display("BAD %0t no read answer", $time);
      close_out();
    end else begin
      chk8(o_rdata, e, "read");
    end
  endtask : get

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (2) @(negedge i_sys_clk);
    chk_ctrl(o_ctrl, model());
    for (int a = 'h15; a <= 'h1B; a++)
      get(a[9:0], 8'h00);
    get(IPLC_OFF_READBACK_SEL, 8'h00);
  endtask : t_reset

  // upper bits of the high byte are junk on purpose: they must be dropped
  task automatic t_divider();
    logic [9:0] v [5] = '{10'h000, 10'h001, 10'h3FF, 10'h155, 10'h200};
    foreach (v[i]) begin
      put(IPLC_OFF_FB_DIV_LOW, v[i][7:0]);
      put(IPLC_OFF_FB_DIV_HIGH, {6'h3F, v[i][9:8]});
      apply(1'b1);
      get(IPLC_OFF_FB_DIV_HIGH, {6'h00, v[i][9:8]});
    end
  endtask : t_divider

  task automatic t_pump();
    for (int i = 0; i < 32; i++) begin
      put(IPLC_OFF_CP_CURRENT, i[0] ? 8'h85 : 8'h7F);
      put(IPLC_OFF_CP_MODE_BKL, {3'h7, i[4:0]});
      apply(1'b1);
    end
    get(IPLC_OFF_CP_MODE_BKL, 8'h1F);
  endtask : t_pump

  // every code, so the oscillator pin select is also seen with differential mode on
  task automatic t_rx();
    for (int i = 0; i < 256; i++) begin
      put(IPLC_OFF_RX_CONTROL, i[7:0]);
      apply(1'b1);
    end
    put(IPLC_OFF_RX_CONTROL, 8'h00);
  endtask : t_rx

  task automatic t_path();
    for (int i = 0; i < 64; i++) begin
      put(IPLC_OFF_FB_PATH_MODE, i[7:0]);
      apply(1'b1);
    end
    put(IPLC_OFF_FB_PATH_MODE, 8'hD0);
    apply(1'b0);
    get(IPLC_OFF_FB_PATH_MODE, 8'h10);
  endtask : t_path

  task automatic t_readback();
    req(1'b1, 1'b0, 1'b0, IPLC_OFF_READBACK_SEL, 8'hFF);
    get(IPLC_OFF_READBACK_SEL, 8'h01);
    put(IPLC_OFF_CP_CURRENT, 8'h5A);
    get(IPLC_OFF_CP_CURRENT, 8'h5A);
    req(1'b1, 1'b0, 1'b0, IPLC_OFF_LOOP_RSVD, 8'hFF);
    get(IPLC_OFF_LOOP_RSVD, 8'h00);
    req(1'b1, 1'b0, 1'b0, IPLC_OFF_READBACK_SEL, 8'h00);
    get(IPLC_OFF_CP_CURRENT, ac[IPLC_OFF_CP_CURRENT]);
    get(10'h3FF, 8'h00);
    apply(1'b1);
    get(IPLC_OFF_CP_CURRENT, 8'h5A);
  endtask : t_readback

  // main sequence: six cycles of reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_divider();
    t_pump();
    t_rx();
    t_path();
    t_readback();
    close_out();
  end

  // watchdog so a stuck handshake cannot hang the run
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    mismatches++;
    $display("BAD %0t run too long", $time);
    close_out();
  end
endmodule : iplc_regs_tb
